// ===== rtl/tape_mark_defs.svh
// Constants of the tape mark and status control: instruction codes,
// mark codes, register fields and timing counts.
// Assumes an 18-bit instruction word and a 50 MHz control clock.
`ifndef TAPE_MARK_DEFS_SVH
`define TAPE_MARK_DEFS_SVH

`define CLK_FREQ_HZ 50000000
`define SEL_DELAY_MS 120
`define SEL_DELAY_CYCLES ((`SEL_DELAY_MS) * ((`CLK_FREQ_HZ) / 1000))

// Processor instruction codes (octal 707541 ... 707601)
`define INSTR_CLEAR_CMD 18'h38f61
`define INSTR_READ_CMD 18'h38f6a
`define INSTR_XOR_CMD 18'h38f64
`define INSTR_LOAD_CMD 18'h38f65
`define INSTR_SKIP_ERR 18'h38f71
`define INSTR_READ_STAT 18'h38f7a
`define INSTR_SKIP_DONE 18'h38f81

// Mark codes as read, first line in the top bit
`define MARK_73 6'h3b
`define MARK_10 6'h08
`define MARK_70 6'h38
`define MARK_25 6'h15
`define MARK_55 6'h2d
`define MARK_22 6'h12
`define MARK_51 6'h29
`define MARK_32 6'h1a
`define MARK_26 6'h16
`define MARK_45 6'h25
`define MARK_07 6'h07
`define FRAME_LINES 3'h6

// Command register fields
`define CMD_WIDTH 10
`define CMD_UNIT_LSB 0
`define CMD_DIR_BIT 3
`define CMD_GO_BIT 4
`define CMD_MODE_BIT 5
`define CMD_FUNC_LSB 6
`define CMD_IEN_BIT 9
`define CMD_RESET 10'h000
`define ACC_KEEP_ERR_BIT 10
`define ACC_KEEP_DONE_BIT 11
`define FUNC_UNUSED 3'h7

// Status register fields
`define STAT_WIDTH 12
`define STAT_ERR_BIT 0
`define STAT_MARK_BIT 1
`define STAT_END_BIT 2
`define STAT_SEL_BIT 3
`define STAT_PAR_BIT 4
`define STAT_TIM_BIT 5
`define STAT_DONE_BIT 11
`define STAT_RESET 12'h000

`endif

// ===== rtl/tape_mark_pkg.sv
// Types shared by the tape mark and status control.
// Assumes tape_mark_defs.svh for the numeric constants.
package tape_mark_pkg;

  typedef struct packed {
    logic valid;
    logic [17:0] code;
    logic [17:0] acc;
  } io_req_t;

  typedef struct packed {
    logic interblock;
    logic block_start;
    logic data_mark;
    logic final_mark;
    logic rev_check;
    logic end_zone;
    logic bad_mark;
  } mark_events_t;

  typedef enum logic [2:0] {
    FN_MOVE = 3'b000,
    FN_SEARCH = 3'b001,
    FN_READ_DATA = 3'b010,
    FN_READ_ALL = 3'b011,
    FN_WRITE_DATA = 3'b100,
    FN_WRITE_ALL = 3'b101,
    FN_WRITE_TIMING = 3'b110,
    FN_UNUSED = 3'b111
  } tape_func_t;

  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_WAIT = 2'b01
  } sel_state_t;

endpackage

// ===== rtl/mark_frame_assembler.sv
// Gathers one mark-track bit per tape line into six-line frames.
// Assumes line_strobe_i is a one-cycle pulse per tape line.
`timescale 1ns/100ps
`include "tape_mark_defs.svh"

module mark_frame_assembler (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic line_strobe_i,
  input wire logic mark_bit_i,
  output logic [5:0] frame_o,
  output logic frame_valid_o
);

  logic [5:0] shift;
  logic [2:0] line_cnt;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift <= 6'h00;
      line_cnt <= 3'h0;
    end else if (!run_i) begin
      line_cnt <= 3'h0;
    end else if (line_strobe_i) begin
      shift <= {shift[4:0], mark_bit_i};
      if (line_cnt == `FRAME_LINES - 3'h1) begin
        line_cnt <= 3'h0;
      end else begin
        line_cnt <= line_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_o <= 6'h00;
      frame_valid_o <= 1'b0;
    end else begin
      frame_valid_o <= run_i && line_strobe_i && (line_cnt == `FRAME_LINES - 3'h1);
      if (run_i && line_strobe_i && (line_cnt == `FRAME_LINES - 3'h1)) begin
        frame_o <= {shift[4:0], mark_bit_i};
      end
    end
  end

  a_frame_six_lines: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    frame_valid_o |-> $past(line_cnt) == 3'h5)
    else $error("frame closed at wrong line");

endmodule // mark_frame_assembler

// ===== rtl/tape_mark_status_control.sv
// Tape control core: mark-track decoding, block checksum, command and
// status registers reached by processor instructions.
// Assumes instruction requests, line strobes and events are synchronous.
`timescale 1ns/100ps
`include "tape_mark_defs.svh"

module tape_mark_status_control #(
  parameter int unsigned SEL_DELAY_CYC = `SEL_DELAY_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire tape_mark_pkg::io_req_t io_req_i,
  output logic acc_load_o,
  output logic [17:0] acc_data_o,
  output logic skip_o,
  input wire logic line_strobe_i,
  input wire logic mark_bit_i,
  input wire logic chk_seed_load_i,
  input wire logic [5:0] chk_seed_i,
  input wire logic word_written_i,
  input wire logic [17:0] word_i,
  input wire logic done_event_i,
  input wire logic parity_err_i,
  output tape_mark_pkg::mark_events_t mark_events_o,
  output logic [5:0] mark_code_o,
  output logic [5:0] checksum_o,
  output logic [2:0] unit_select_o,
  output logic reverse_o,
  output logic go_o,
  output logic continuous_o,
  output logic [2:0] function_o,
  output logic irq_enable_o,
  output logic select_busy_o,
  output logic irq_o
);

  import tape_mark_pkg::*;

  function automatic logic [5:0] obverse(input logic [5:0] c);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      r[i] = ~c[5 - i];
    end
    return r;
  endfunction

  function automatic logic mark_known(input logic [5:0] c);
    logic k;
    k = (c == `MARK_73) || (c == `MARK_10) || (c == `MARK_70) || (c == `MARK_25) ||
        (c == `MARK_55) || (c == `MARK_22) || (c == `MARK_51) || (c == `MARK_32) ||
        (c == `MARK_26) || (c == `MARK_45);
    return k;
  endfunction

  function automatic logic [5:0] equiv6(input logic [5:0] a, input logic [5:0] b);
    return ~(a ^ b);
  endfunction

  logic [`CMD_WIDTH-1:0] cmd;
  logic [`STAT_WIDTH-1:0] stat;
  logic [5:0] frame;
  logic frame_valid;
  logic [5:0] fwd_code;
  logic reverse_direction;
  logic is_clear;
  logic is_xor;
  logic is_load;
  logic cmd_write;
  logic [`CMD_WIDTH-1:0] next_cmd;
  logic sel_check;
  logic [31:0] sel_cnt;
  sel_state_t sel_state;
  logic end_err;
  logic tim_err;
  logic clr_err;
  logic clr_done;

  assign reverse_direction = cmd[`CMD_DIR_BIT];
  assign is_clear = io_req_i.valid && (io_req_i.code == `INSTR_CLEAR_CMD);
  assign is_xor = io_req_i.valid && (io_req_i.code == `INSTR_XOR_CMD);
  assign is_load = io_req_i.valid && (io_req_i.code == `INSTR_LOAD_CMD);
  assign cmd_write = is_xor || is_load;
  // Forward view of the frame, so block marks decode alike both ways
  assign fwd_code = reverse_direction ? obverse(frame) : frame;

  mark_frame_assembler u_frame (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .run_i(cmd[`CMD_GO_BIT]),
    .line_strobe_i(line_strobe_i),
    .mark_bit_i(mark_bit_i),
    .frame_o(frame),
    .frame_valid_o(frame_valid)
  );

  // Command register
  always_comb begin
    next_cmd = cmd;
    if (is_clear) begin
      next_cmd = `CMD_RESET;
    end else if (is_xor) begin
      next_cmd = cmd ^ io_req_i.acc[`CMD_WIDTH-1:0];
    end else if (is_load) begin
      next_cmd = io_req_i.acc[`CMD_WIDTH-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd <= `CMD_RESET;
    end else begin
      cmd <= next_cmd;
    end
  end

  // Command fields to the transport side
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unit_select_o <= 3'h0;
      reverse_o <= 1'b0;
      go_o <= 1'b0;
      continuous_o <= 1'b0;
      function_o <= 3'h0;
      irq_enable_o <= 1'b0;
    end else begin
      unit_select_o <= next_cmd[`CMD_UNIT_LSB +: 3];
      reverse_o <= next_cmd[`CMD_DIR_BIT];
      go_o <= next_cmd[`CMD_GO_BIT];
      continuous_o <= next_cmd[`CMD_MODE_BIT];
      function_o <= next_cmd[`CMD_FUNC_LSB +: 3];
      irq_enable_o <= next_cmd[`CMD_IEN_BIT];
    end
  end

  // Select delay after an XOR command with accumulator bits 4:0 all set
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_state <= SEL_IDLE;
      sel_cnt <= 32'h0;
      select_busy_o <= 1'b0;
    end else begin
      unique case (sel_state)
        SEL_IDLE: begin
          if (is_xor && (io_req_i.acc[4:0] == 5'h1f)) begin
            sel_state <= SEL_WAIT;
            sel_cnt <= 32'(SEL_DELAY_CYC) - 32'h1;
            select_busy_o <= 1'b1;
          end
        end
        SEL_WAIT: begin
          if (sel_cnt == 32'h0) begin
            sel_state <= SEL_IDLE;
            select_busy_o <= 1'b0;
          end else begin
            sel_cnt <= sel_cnt - 32'h1;
          end
        end
      endcase
    end
  end

  // Select check runs the cycle after a command write
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_check <= 1'b0;
    end else begin
      sel_check <= cmd_write;
    end
  end

  // Mark decoding, registered event pulses
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mark_events_o <= '0;
      mark_code_o <= 6'h00;
    end else begin
      mark_events_o <= '0;
      if (frame_valid) begin
        mark_code_o <= frame;
        mark_events_o.interblock <= (frame == `MARK_25);
        mark_events_o.data_mark <= (frame == `MARK_70);
        mark_events_o.block_start <= (fwd_code == `MARK_26);
        mark_events_o.end_zone <= reverse_direction ? (frame == `MARK_22) : (frame == `MARK_55);
        mark_events_o.final_mark <= !reverse_direction && (frame == `MARK_73);
        mark_events_o.rev_check <= reverse_direction && (frame == `MARK_10);
        mark_events_o.bad_mark <= !mark_known(frame);
      end
    end
  end

  // Block checksum over every six bits written
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      checksum_o <= 6'h00;
    end else if (chk_seed_load_i) begin
      checksum_o <= chk_seed_i;
    end else if (word_written_i) begin
      checksum_o <= equiv6(equiv6(equiv6(checksum_o, word_i[17:12]), word_i[11:6]),
                           word_i[5:0]);
    end
  end

  // Status register: sets win over clears
  assign clr_err = cmd_write && !io_req_i.acc[`ACC_KEEP_ERR_BIT];
  assign clr_done = cmd_write && !io_req_i.acc[`ACC_KEEP_DONE_BIT];
  assign end_err = mark_events_o.end_zone && cmd[`CMD_GO_BIT];
  assign tim_err = done_event_i && stat[`STAT_DONE_BIT];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat <= `STAT_RESET;
    end else begin
      if (clr_err) begin
        stat[5:0] <= 6'h00;
      end
      if (clr_done) begin
        stat[`STAT_DONE_BIT] <= 1'b0;
      end
      if (done_event_i) begin
        stat[`STAT_DONE_BIT] <= 1'b1;
      end
      if (mark_events_o.bad_mark) begin
        stat[`STAT_MARK_BIT] <= 1'b1;
        stat[`STAT_ERR_BIT] <= 1'b1;
      end
      if (end_err) begin
        stat[`STAT_END_BIT] <= 1'b1;
        stat[`STAT_ERR_BIT] <= 1'b1;
      end
      if (sel_check && (cmd[`CMD_FUNC_LSB +: 3] == `FUNC_UNUSED)) begin
        stat[`STAT_SEL_BIT] <= 1'b1;
        stat[`STAT_ERR_BIT] <= 1'b1;
      end
      if (parity_err_i) begin
        stat[`STAT_PAR_BIT] <= 1'b1;
        stat[`STAT_ERR_BIT] <= 1'b1;
      end
      if (tim_err) begin
        stat[`STAT_TIM_BIT] <= 1'b1;
        stat[`STAT_ERR_BIT] <= 1'b1;
      end
    end
  end

  // Instruction answers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_load_o <= 1'b0;
      acc_data_o <= 18'h00000;
      skip_o <= 1'b0;
    end else begin
      acc_load_o <= 1'b0;
      skip_o <= 1'b0;
      if (io_req_i.valid) begin
        if (io_req_i.code == `INSTR_READ_CMD) begin
          acc_load_o <= 1'b1;
          acc_data_o <= {8'h00, cmd};
        end else if (io_req_i.code == `INSTR_READ_STAT) begin
          acc_load_o <= 1'b1;
          acc_data_o <= {6'h00, stat};
        end else if (io_req_i.code == `INSTR_SKIP_ERR) begin
          skip_o <= stat[`STAT_ERR_BIT];
        end else if (io_req_i.code == `INSTR_SKIP_DONE) begin
          skip_o <= stat[`STAT_DONE_BIT];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= cmd[`CMD_IEN_BIT] && (stat[`STAT_ERR_BIT] || stat[`STAT_DONE_BIT]);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_obverse_self_inverse: assert property (
    frame_valid |-> obverse(obverse(frame)) == frame &&
    obverse(`MARK_07) == `MARK_07 && obverse(`MARK_25) == `MARK_25 &&
    obverse(`MARK_70) == `MARK_70 && obverse(`MARK_45) == `MARK_26)
    else $error("complement obverse wrong");

  a_block_both_dirs: assert property (
    frame_valid && ((!reverse_direction && frame == `MARK_26) || (reverse_direction && frame == `MARK_45))
    |=> mark_events_o.block_start)
    else $error("block start missed");

  a_end_zone_dir: assert property (
    frame_valid && reverse_direction && frame == `MARK_22 |=> mark_events_o.end_zone)
    else $error("reverse end zone missed");

  a_clear_keeps_flags: assert property (
    is_clear && !done_event_i && !parity_err_i && !mark_events_o.bad_mark && !end_err &&
    !sel_check |=> cmd == `CMD_RESET && $stable(stat))
    else $error("clear-command disturbed flags");

  a_xor_updates_cmd: assert property (
    is_xor |=> cmd == ($past(cmd) ^ $past(io_req_i.acc[9:0])))
    else $error("xor-command result wrong");

  a_load_then_read: assert property (
    is_load ##1 (io_req_i.valid && io_req_i.code == `INSTR_READ_CMD)
    |=> acc_load_o && acc_data_o == {8'h00, $past(io_req_i.acc[9:0], 2)})
    else $error("load-command not read back");

  a_error_clear_bit10: assert property (
    cmd_write && !io_req_i.acc[10] && !parity_err_i && !tim_err &&
    !mark_events_o.bad_mark && !end_err && !sel_check |=> stat[5:0] == 6'h00)
    else $error("errors not cleared");

  a_timing_error: assert property (
    done_event_i && stat[11] |=> stat[5] && stat[0] && stat[11])
    else $error("timing error not raised");

  a_skip_on_done: assert property (
    io_req_i.valid && io_req_i.code == `INSTR_SKIP_DONE && stat[11] |=> skip_o)
    else $error("skip on done missing");

  a_select_error: assert property (
    is_load && io_req_i.acc[8:6] == 3'h7 |=> ##1 stat[3] && stat[0])
    else $error("select error missing");

  a_select_delay: assert property (
    sel_state == SEL_IDLE && is_xor && io_req_i.acc[4:0] == 5'h1f
    |=> select_busy_o [*3])
    else $error("select delay not held");

  a_bad_mark_flag: assert property (
    frame_valid && !mark_known(frame) |=> ##1 stat[1] && stat[0])
    else $error("mark error not flagged");

endmodule // tape_mark_status_control

// ===== bench/tape_transport_model.sv
// Tape transport mark channel as seen at the read head of the control.
// Assumes the bench calls send once per mark frame while go is set.
`timescale 1ns/100ps

module tape_transport_model (
  input wire logic ref_clk_i,
  input wire logic reverse_i,
  output logic line_strobe_o,
  output logic mark_bit_o
);
  logic [5:0] head;

  initial begin
    line_strobe_o = 1'b0;
    mark_bit_o = 1'b0;
    head = 6'h00;
  end

  // Complement every bit and reverse their order
  function automatic logic [5:0] obverse(input logic [5:0] c);
    obverse = ~{c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction

  // Code at the head, the obverse of the recorded code in reverse, goes out one line per strobe, first line first
  task automatic send(input logic [5:0] rec, input int gap);
    head = reverse_i ? obverse(rec) : rec;
    for (int i = 5; i >= 0; i--) begin
      @(negedge ref_clk_i);
      line_strobe_o = 1'b1;
      mark_bit_o = head[i];
      @(negedge ref_clk_i);
      line_strobe_o = 1'b0;
      // Off the strobe the line carries nothing useful
      mark_bit_o = ~head[i];
      repeat (gap) @(negedge ref_clk_i);
    end
  endtask
endmodule // tape_transport_model

// ===== bench/tb.sv
// Self-checking bench for the tape mark and status control.
// Assumes the transport model drives the mark channel and tb the rest.
`timescale 1ns/100ps
`include "tape_mark_defs.svh"

module tb;
  import tape_mark_pkg::*;
  localparam int unsigned SEL_CYC = 8;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  io_req_t io_req = '0;
  logic seed_ld = 1'b0, wr = 1'b0, done_ev = 1'b0, par_err = 1'b0;
  logic [5:0] seed = 6'h00, cks, code_seen, c;
  logic [17:0] word = 18'h00000, acc_data, got_data;
  logic acc_load, skip, strobe, mbit, reverse_direction, go, cont, ien, busy, irq;
  logic [2:0] unit, func;
  logic got_load, got_skip;
  mark_events_t ev, seen_ev;
  int busy_cnt, num_errors = 0, cmp_count = 0;
  logic [18:0] tbl [11] = '{
    {`MARK_26, `MARK_26, 7'h20}, {`MARK_25, `MARK_25, 7'h40}, {`MARK_70, `MARK_70, 7'h10},
    {`MARK_73, `MARK_73, 7'h08}, {`MARK_45, `MARK_45, 7'h00}, {`MARK_55, `MARK_55, 7'h02},
    {`MARK_26, `MARK_45, 7'h20}, {`MARK_73, `MARK_10, 7'h04}, {`MARK_70, `MARK_70, 7'h10},
    {`MARK_25, `MARK_25, 7'h40}, {`MARK_55, `MARK_22, 7'h02}};

  always #10 ref_clk_i = ~ref_clk_i;

  tape_mark_status_control #(.SEL_DELAY_CYC(SEL_CYC)) dut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .io_req_i(io_req),
    .acc_load_o(acc_load), .acc_data_o(acc_data), .skip_o(skip),
    .line_strobe_i(strobe), .mark_bit_i(mbit), .chk_seed_load_i(seed_ld),
    .chk_seed_i(seed), .word_written_i(wr), .word_i(word), .done_event_i(done_ev),
    .parity_err_i(par_err), .mark_events_o(ev), .mark_code_o(code_seen),
    .checksum_o(cks), .unit_select_o(unit), .reverse_o(reverse_direction), .go_o(go),
    .continuous_o(cont), .function_o(func), .irq_enable_o(ien),
    .select_busy_o(busy), .irq_o(irq));

  tape_transport_model xport (.ref_clk_i(ref_clk_i), .reverse_i(reverse_direction),
    .line_strobe_o(strobe), .mark_bit_o(mbit));

  // Pulses are caught here so that no one-cycle answer slips past
  always @(posedge ref_clk_i) begin
    if (acc_load === 1'b1) begin
      got_load <= 1'b1;
      got_data <= acc_data;
    end
    if (skip === 1'b1) got_skip <= 1'b1;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    seen_ev <= seen_ev | ev;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string name, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic io(input logic [17:0] code, input logic [17:0] acc);
    @(negedge ref_clk_i);
    got_load = 1'b0;
    got_skip = 1'b0;
    busy_cnt = 0;
    io_req = '{valid: 1'b1, code: code, acc: acc};
    @(negedge ref_clk_i);
    io_req.valid = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask

  // Two instructions on consecutive cycles, the second without accumulator
  task automatic io_pair(input logic [17:0] code1, input logic [17:0] acc1,
                         input logic [17:0] code2);
    @(negedge ref_clk_i);
    got_load = 1'b0;
    got_skip = 1'b0;
    busy_cnt = 0;
    io_req = '{valid: 1'b1, code: code1, acc: acc1};
    @(negedge ref_clk_i);
    io_req = '{valid: 1'b1, code: code2, acc: 18'h00000};
    @(negedge ref_clk_i);
    io_req.valid = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask

  task automatic rd(input logic [17:0] code, input string name, input logic [17:0] exp);
    io(code, 18'h00000);
    chk_val("acc load", 18'h00001, {17'h00000, got_load});
    chk_val(name, exp, got_data);
  endtask

  task automatic pulse_in(input logic d, input logic p);
    @(negedge ref_clk_i);
    done_ev = d;
    par_err = p;
    @(negedge ref_clk_i);
    done_ev = 1'b0;
    par_err = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic mark(input logic [5:0] rec, input logic [5:0] code, input logic [6:0] exp,
                      input int gap);
    seen_ev = '0;
    xport.send(rec, gap);
    repeat (5) @(negedge ref_clk_i);
    chk_val("mark code", {12'h000, code}, {12'h000, code_seen});
    chk_val("events", {11'h000, exp}, {11'h000, seen_ev});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    $display("Error watchdog expected finish seen hang");
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    rd(`INSTR_READ_CMD, "command", 18'h00000);
    rd(`INSTR_READ_STAT, "status", 18'h00000);
    io(`INSTR_LOAD_CMD, 18'h00e55);
    chk_val("fields", 18'h00255, {8'h00, ien, func, cont, go, reverse_direction, unit});
    rd(`INSTR_READ_CMD, "command", 18'h00255);
    io(18'h38f62, 18'h00fff);
    chk_val("unknown", 18'h00000, {16'h0000, got_load, got_skip});
    io(`INSTR_XOR_CMD, 18'h00c3a);
    chk_val("no delay", 18'h00000, 18'(busy_cnt));
    io(`INSTR_XOR_CMD, 18'h00c1f);
    repeat (12) @(negedge ref_clk_i);
    chk_val("delay", 18'(SEL_CYC), 18'(busy_cnt));
    rd(`INSTR_READ_CMD, "command", 18'h00270);
    $display("test registers done");
    pulse_in(1'b1, 1'b0);
    rd(`INSTR_READ_STAT, "status", 18'h00800);
    chk_val("irq", 18'h00001, {17'h00000, irq});
    io(`INSTR_SKIP_DONE, 18'h00000);
    chk_val("skip done", 18'h00001, {17'h00000, got_skip});
    io(`INSTR_SKIP_ERR, 18'h00000);
    chk_val("skip err", 18'h00000, {17'h00000, got_skip});
    io(`INSTR_CLEAR_CMD, 18'h00000);
    rd(`INSTR_READ_CMD, "command", 18'h00000);
    rd(`INSTR_READ_STAT, "status", 18'h00800);
    pulse_in(1'b1, 1'b0);
    rd(`INSTR_READ_STAT, "status", 18'h00821);
    io(`INSTR_SKIP_ERR, 18'h00000);
    chk_val("skip err", 18'h00001, {17'h00000, got_skip});
    pulse_in(1'b0, 1'b1);
    rd(`INSTR_READ_STAT, "status", 18'h00831);
    io(`INSTR_XOR_CMD, 18'h00000);
    rd(`INSTR_READ_STAT, "status", 18'h00000);
    io(`INSTR_LOAD_CMD, 18'h00dc0);
    rd(`INSTR_READ_STAT, "status", 18'h00009);
    rd(`INSTR_READ_CMD, "command", 18'h001c0);
    io_pair(`INSTR_LOAD_CMD, 18'h0002b, `INSTR_READ_CMD);
    chk_val("load read", 18'h0002b, got_data);
    rd(`INSTR_READ_STAT, "status", 18'h00000);
    $display("test flags done");
    io(`INSTR_LOAD_CMD, 18'h00c11);
    for (int i = 0; i < 11; i++) begin
      if (i == 6) io(`INSTR_LOAD_CMD, 18'h00c19);
      mark(tbl[i][18:13], tbl[i][12:7], tbl[i][6:0], (i < 6) ? 1 : 3);
    end
    rd(`INSTR_READ_STAT, "status", 18'h00005);
    mark(6'h01, 6'h1f, 7'h01, 2);
    rd(`INSTR_READ_STAT, "status", 18'h00007);
    $display("test marks done");
    @(negedge ref_clk_i);
    seed = 6'h2a;
    seed_ld = 1'b1;
    @(negedge ref_clk_i);
    seed_ld = 1'b0;
    c = 6'h2a;
    for (int w = 0; w < 2; w++) begin
      word = (w == 0) ? 18'h3c96a : 18'h05af0;
      for (int g = 0; g < 3; g++) c = ~(c ^ word[17 - 6 * g -: 6]);
      wr = 1'b1;
      @(negedge ref_clk_i);
      wr = 1'b0;
      repeat (2) @(negedge ref_clk_i);
    end
    chk_val("checksum", {12'h000, c}, {12'h000, cks});
    $display("test checksum done");
    report_and_stop();
  end
endmodule // tb
